// File: rtl/plsl_pkg.sv
// Package with register map, field layout, reset values and codes for the PHY test/LED registers
package plsl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus geometry
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;

  // Register offsets
  localparam logic [4:0] SELFTEST_CONTROL_LOOP_POINT_OFS = 5'h16;
  localparam logic [4:0] TEST_AND_POWER_STATUS_OFS       = 5'h17;
  localparam logic [4:0] LED_SOURCE_SELECT_OFS           = 5'h18;

  ////////////////////////////////////////////////////////////////////////////
  // Self-test control: loop point field
  localparam int unsigned  LOOP_POINT_LSB   = 0;
  localparam int unsigned  LOOP_POINT_W     = 2;
  localparam logic [1:0]   LOOP_POINT_RESET = 2'h0;
  localparam logic [1:0]   LOOP_AFTER_ENC   = 2'h3;
  localparam logic [1:0]   LOOP_AFTER_SCR   = 2'h2;
  localparam logic [1:0]   LOOP_BEFORE_SCR  = 2'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Status register bit positions
  localparam int unsigned STS_LOCKED_BIT  = 11;
  localparam int unsigned STS_DROPPED_BIT = 10;
  localparam int unsigned STS_PKTGEN_BIT  = 9;
  localparam int unsigned STS_SCR_MST_BIT = 8;
  localparam int unsigned STS_SCR_SLV_BIT = 7;
  localparam int unsigned STS_POWER_BIT   = 6;
  localparam logic [15:0] STS_RESET       = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // LED source select fields and reset value
  localparam int unsigned SRC_W           = 4;
  localparam int unsigned GP_LED_SRC_LSB  = 12;
  localparam int unsigned LED_TWO_SRC_LSB = 8;
  localparam int unsigned LED_ONE_SRC_LSB = 4;
  localparam int unsigned LED_ZERO_SRC_LSB = 0;
  localparam logic [15:0] LED_SOURCE_SELECT_RESET = 16'h6150;

  // Link speed encoding on i_link_speed
  localparam logic [1:0] SPEED_10   = 2'h0;
  localparam logic [1:0] SPEED_100  = 2'h1;
  localparam logic [1:0] SPEED_1000 = 2'h2;

  // Activity blink half period
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned BLINK_HALF_MS = 100;
  localparam int unsigned BLINK_COUNT_W = 24;

  typedef enum logic [3:0] {
    PLSL_SRC_LINK      = 4'h0,
    PLSL_SRC_RXTX_ACT  = 4'h1,
    PLSL_SRC_TX_ACT    = 4'h2,
    PLSL_SRC_RX_ACT    = 4'h4,
    PLSL_SRC_LINK_1000 = 4'h5,
    PLSL_SRC_LINK_100  = 4'h6,
    PLSL_SRC_LINK_10   = 4'h7,
    PLSL_SRC_LINK_10_100 = 4'h8,
    PLSL_SRC_LINK_100_1000 = 4'h9,
    PLSL_SRC_FULL_DUPLEX = 4'hA,
    PLSL_SRC_LINK_BLINK  = 4'hB,
    PLSL_SRC_RSVD_C      = 4'hC,
    PLSL_SRC_RXTX_ERR    = 4'hD,
    PLSL_SRC_RX_ERR      = 4'hE,
    PLSL_SRC_RSVD_F      = 4'hF
  } plsl_led_src_t;

endpackage : plsl_pkg

// File: rtl/plsl_regs.sv
// Loop point control, test/power status and LED source selection registers
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - 100M code 11 loops after line encoder
// - 100M code 10 loops after scrambler
// - 100M code 01 loops before scrambler
// - Gigabit low bit set loops before DSP
// - Status shows checker locked level
// - Lock loss latches until status read
// - Status shows packet generator busy
// - Status shows master legacy encoding
// - Status shows slave legacy encoding
// - Status shows core normal power
// - Unused status bits read zero, ignore writes
// - Four 4-bit LED source selectors
// - Selectors reset to 0110 0001 0101 0000
// - 1110 receive error, 1101 either error
// - 1011 link lit, blinks on activity
// - 1001 100/1000 link, 1000 10/100 link
// - 0111 10M, 0110 100M, 0101 1000M link
// - 0010 transmit, 0001 either activity
module plsl_regs #(
  parameter int unsigned BLINK_HALF_CYCLES =
    plsl_pkg::BLINK_HALF_MS * 1000000 / plsl_pkg::CLK_PERIOD_NS
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rstn,
  input  wire logic [4:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  input  wire logic [1:0]  i_link_speed,
  input  wire logic        i_link_up,
  input  wire logic        i_full_duplex,
  input  wire logic        i_rx_active,
  input  wire logic        i_tx_active,
  input  wire logic        i_rx_error,
  input  wire logic        i_tx_error,
  input  wire logic        i_checker_locked,
  input  wire logic        i_packet_generator_active,
  input  wire logic        i_gigabit_scrambler_legacy_flag,
  input  wire logic        i_slave_scrambler_legacy_flag,
  input  wire logic        i_core_power_state,
  output logic             o_loop_after_line_encoder,
  output logic             o_loop_after_scrambler,
  output logic             o_loop_before_scrambler,
  output logic             o_loop_before_gigabit_dsp,
  output logic             o_gp_led_output,
  output logic             o_led_two_output,
  output logic             o_led_one_output,
  output logic             o_led_zero_output
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [1:0]  loop_point_select;
  logic [15:0] led_source_select;
  logic        checker_lock_dropped;
  logic        prev_locked;
  logic        lock_fall;
  logic        sts_read;
  logic        blink_phase;
  logic [plsl_pkg::BLINK_COUNT_W-1:0] blink_count;
  logic [15:0] src_event;
  logic [3:0]  next_led;
  logic [3:0]  led_q;
  logic [15:0] next_rdata;
  logic        link_10;
  logic        link_100;
  logic        link_1000;

  assign sts_read  = i_rd && (i_addr == plsl_pkg::TEST_AND_POWER_STATUS_OFS);
  assign lock_fall = prev_locked && !i_checker_locked;
  assign link_10   = i_link_up && (i_link_speed == plsl_pkg::SPEED_10);
  assign link_100  = i_link_up && (i_link_speed == plsl_pkg::SPEED_100);
  assign link_1000 = i_link_up && (i_link_speed == plsl_pkg::SPEED_1000);

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      loop_point_select <= plsl_pkg::LOOP_POINT_RESET;
    end else if (i_wr && (i_addr == plsl_pkg::SELFTEST_CONTROL_LOOP_POINT_OFS)) begin
      loop_point_select <= i_wdata[plsl_pkg::LOOP_POINT_LSB +: plsl_pkg::LOOP_POINT_W];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      led_source_select <= plsl_pkg::LED_SOURCE_SELECT_RESET;
    end else if (i_wr && (i_addr == plsl_pkg::LED_SOURCE_SELECT_OFS)) begin
      led_source_select <= i_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lock-loss latch; a new loss in the read cycle survives the clear
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      prev_locked <= 1'b0;
    end else begin
      prev_locked <= i_checker_locked;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      checker_lock_dropped <= 1'b0;
    end else if (lock_fall) begin
      checker_lock_dropped <= 1'b1;
    end else if (sts_read) begin
      checker_lock_dropped <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, valid only in the cycle after the read strobe
  always_comb begin
    next_rdata = 16'h0000;
    if (i_rd) begin
      unique case (i_addr)
        plsl_pkg::SELFTEST_CONTROL_LOOP_POINT_OFS: begin
          next_rdata[plsl_pkg::LOOP_POINT_LSB +: plsl_pkg::LOOP_POINT_W] = loop_point_select;
        end
        plsl_pkg::TEST_AND_POWER_STATUS_OFS: begin
          next_rdata = plsl_pkg::STS_RESET;
          next_rdata[plsl_pkg::STS_LOCKED_BIT]  = i_checker_locked;
          next_rdata[plsl_pkg::STS_DROPPED_BIT] = checker_lock_dropped;
          next_rdata[plsl_pkg::STS_PKTGEN_BIT]  = i_packet_generator_active;
          next_rdata[plsl_pkg::STS_SCR_MST_BIT] = i_gigabit_scrambler_legacy_flag;
          next_rdata[plsl_pkg::STS_SCR_SLV_BIT] = i_slave_scrambler_legacy_flag;
          next_rdata[plsl_pkg::STS_POWER_BIT]   = i_core_power_state;
        end
        plsl_pkg::LED_SOURCE_SELECT_OFS: begin
          next_rdata = led_source_select;
        end
        default: begin
          next_rdata = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= 16'h0000;
    end else begin
      o_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Loop point decode by link speed
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_loop_after_line_encoder <= 1'b0;
      o_loop_after_scrambler    <= 1'b0;
      o_loop_before_scrambler   <= 1'b0;
      o_loop_before_gigabit_dsp <= 1'b0;
    end else begin
      o_loop_after_line_encoder <= (i_link_speed == plsl_pkg::SPEED_100) &&
                                   (loop_point_select == plsl_pkg::LOOP_AFTER_ENC);
      o_loop_after_scrambler    <= (i_link_speed == plsl_pkg::SPEED_100) &&
                                   (loop_point_select == plsl_pkg::LOOP_AFTER_SCR);
      o_loop_before_scrambler   <= (i_link_speed == plsl_pkg::SPEED_100) &&
                                   (loop_point_select == plsl_pkg::LOOP_BEFORE_SCR);
      o_loop_before_gigabit_dsp <= (i_link_speed == plsl_pkg::SPEED_1000) &&
                                   loop_point_select[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Activity blink timebase
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      blink_count <= '0;
      blink_phase <= 1'b0;
    end else if (blink_count == plsl_pkg::BLINK_COUNT_W'(BLINK_HALF_CYCLES - 1)) begin
      blink_count <= '0;
      blink_phase <= !blink_phase;
    end else begin
      blink_count <= blink_count + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event vector indexed by selector code; reserved codes stay dark
  always_comb begin
    src_event = 16'h0000;
    src_event[plsl_pkg::PLSL_SRC_LINK]          = i_link_up;
    src_event[plsl_pkg::PLSL_SRC_RXTX_ACT]      = i_rx_active || i_tx_active;
    src_event[plsl_pkg::PLSL_SRC_TX_ACT]        = i_tx_active;
    src_event[plsl_pkg::PLSL_SRC_RX_ACT]        = i_rx_active;
    src_event[plsl_pkg::PLSL_SRC_LINK_1000]     = link_1000;
    src_event[plsl_pkg::PLSL_SRC_LINK_100]      = link_100;
    src_event[plsl_pkg::PLSL_SRC_LINK_10]       = link_10;
    src_event[plsl_pkg::PLSL_SRC_LINK_10_100]   = link_10 || link_100;
    src_event[plsl_pkg::PLSL_SRC_LINK_100_1000] = link_100 || link_1000;
    src_event[plsl_pkg::PLSL_SRC_FULL_DUPLEX]   = i_link_up && i_full_duplex;
    src_event[plsl_pkg::PLSL_SRC_LINK_BLINK]    =
      i_link_up && !((i_rx_active || i_tx_active) && blink_phase);
    src_event[plsl_pkg::PLSL_SRC_RXTX_ERR]      = i_rx_error || i_tx_error;
    src_event[plsl_pkg::PLSL_SRC_RX_ERR]        = i_rx_error;
  end

  // One selector per LED, highest field drives the general-purpose LED
  for (genvar g = 0; g < 4; g++) begin : g_led
    assign next_led[g] = src_event[led_source_select[g*plsl_pkg::SRC_W +: plsl_pkg::SRC_W]];
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      led_q <= 4'h0;
    end else begin
      led_q <= next_led;
    end
  end

  assign o_gp_led_output   = led_q[3];
  assign o_led_two_output  = led_q[2];
  assign o_led_one_output  = led_q[1];
  assign o_led_zero_output = led_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  sequence sts_rd_s;
    i_rd && (i_addr == plsl_pkg::TEST_AND_POWER_STATUS_OFS);
  endsequence

  loop_after_enc_a: assert property (
    (i_link_speed == 2'h1 && loop_point_select == 2'h3) |=> o_loop_after_line_encoder
  ) else $error("100M loop after line encoder not selected");

  loop_after_scr_a: assert property (
    (i_link_speed == 2'h1 && loop_point_select == 2'h2) |=>
      (o_loop_after_scrambler && !o_loop_after_line_encoder)
  ) else $error("100M loop after scrambler not selected");

  loop_before_scr_a: assert property (
    (i_link_speed == 2'h1 && loop_point_select == 2'h1) |=>
      (o_loop_before_scrambler && !o_loop_after_scrambler)
  ) else $error("100M loop before scrambler not selected");

  loop_gig_dsp_a: assert property (
    (i_link_speed == 2'h2) |=> (o_loop_before_gigabit_dsp == $past(loop_point_select[0]))
  ) else $error("Gigabit loop point does not follow low select bit");

  lock_level_a: assert property (
    sts_rd_s |=> (o_rdata[11] == $past(i_checker_locked))
  ) else $error("Locked bit does not match checker");

  lock_drop_hold_a: assert property (
    (prev_locked && !i_checker_locked) ##1 sts_rd_s |=> o_rdata[10]
  ) else $error("Lock loss not reported");

  lock_drop_clear_a: assert property (
    (sts_read && !lock_fall) ##1 (!lock_fall) ##1 sts_rd_s |=> !o_rdata[10]
  ) else $error("Lock loss not cleared by read");

  lock_drop_set_a: assert property (
    lock_fall |=> checker_lock_dropped
  ) else $error("Lock loss not latched");

  loop_wr_a: assert property (
    (i_wr && i_addr == 5'h16) |=> (loop_point_select == $past(i_wdata[1:0]))
  ) else $error("Loop point write lost");

  loop_off_a: assert property (
    (i_link_speed != 2'h1) |=>
      !(o_loop_after_line_encoder || o_loop_after_scrambler || o_loop_before_scrambler)
  ) else $error("100M loop point active at other speed");

  pktgen_busy_a: assert property (
    sts_rd_s |=> (o_rdata[9] == $past(i_packet_generator_active))
  ) else $error("Packet generator busy bit wrong");

  scr_master_a: assert property (
    sts_rd_s |=> (o_rdata[8] == $past(i_gigabit_scrambler_legacy_flag))
  ) else $error("Master scrambler mode bit wrong");

  scr_slave_a: assert property (
    sts_rd_s |=> (o_rdata[7] == $past(i_slave_scrambler_legacy_flag))
  ) else $error("Slave scrambler mode bit wrong");

  core_power_a: assert property (
    sts_rd_s |=> (o_rdata[6] == $past(i_core_power_state))
  ) else $error("Core power bit wrong");

  sts_unused_a: assert property (
    sts_rd_s |=> (o_rdata[15:12] == 4'h0 && o_rdata[5:0] == 6'h00)
  ) else $error("Unused status bits not zero");

  led_select_wr_a: assert property (
    (i_wr && i_addr == 5'h18) |=> (led_source_select == $past(i_wdata))
  ) else $error("LED source select write lost");

  led_reset_a: assert property (
    $rose(i_rstn) |-> (led_source_select == 16'h6150)
  ) else $error("LED selectors not at reset value");

  led_rx_err_a: assert property (
    (led_source_select[3:0] == 4'hE) |=> (o_led_zero_output == $past(i_rx_error))
  ) else $error("Receive error source wrong");

  led_blink_a: assert property (
    (led_source_select[3:0] == 4'hB && !i_link_up) |=> !o_led_zero_output
  ) else $error("Blink source lit without link");

  led_gig_link_a: assert property (
    (led_source_select[7:4] == 4'h9 && i_link_up && i_link_speed == 2'h2) |=> o_led_one_output
  ) else $error("100/1000 link source not lit");

  led_speed_a: assert property (
    (led_source_select[15:12] == 4'h6) |=>
      (o_gp_led_output == $past(i_link_up && i_link_speed == 2'h1))
  ) else $error("100M link source wrong");

  led_low_speed_a: assert property (
    (led_source_select[15:12] == 4'h8) |=>
      (o_gp_led_output == $past(i_link_up && !i_link_speed[1]))
  ) else $error("10/100 link source wrong");

  led_any_link_a: assert property (
    (led_source_select[7:4] == 4'h0) |=> (o_led_one_output == $past(i_link_up))
  ) else $error("Any link source wrong");

  led_err_either_a: assert property (
    (led_source_select[11:8] == 4'hD) |=> (o_led_two_output == $past(i_rx_error || i_tx_error))
  ) else $error("Either error source wrong");

  led_tx_act_a: assert property (
    (led_source_select[11:8] == 4'h2) |=> (o_led_two_output == $past(i_tx_active))
  ) else $error("Transmit activity source wrong");

  led_duplex_a: assert property (
    (led_source_select[3:0] == 4'hA) |=>
      (o_led_zero_output == $past(i_link_up && i_full_duplex))
  ) else $error("Full duplex source wrong");

  led_rx_act_a: assert property (
    (led_source_select[3:0] == 4'h4) |=> (o_led_zero_output == $past(i_rx_active))
  ) else $error("Receive activity source wrong");

  led_reserved_a: assert property (
    (led_source_select[3:0] == 4'hF || led_source_select[3:0] == 4'hC) |=> !o_led_zero_output
  ) else $error("Reserved source lit LED");

  rd_only_once_a: assert property (
    !i_rd |=> (o_rdata == 16'h0000)
  ) else $error("Read data outside read slot");

  lock_loss_c: cover property (
    (prev_locked && !i_checker_locked) ##1 sts_rd_s ##1 o_rdata[10]
  );

  loop_full_c: cover property (
    o_loop_after_line_encoder ##[1:20] o_loop_before_gigabit_dsp
  );

  blink_c: cover property (
    (led_source_select[3:0] == 4'hB) && i_link_up && i_rx_active ##1 !o_led_zero_output
  );

  led_remap_c: cover property (
    (i_wr && i_addr == 5'h18) ##1 (led_source_select != 16'h6150)
  );

endmodule // plsl_regs

// File: testbench/tb.sv
// Self-checking testbench for the loop point, status and LED source registers
`timescale 1ns/10ps

module tb;

  ////////////////////////////////////////////////////////////////////////////
  logic        i_ref_clk = 1'b0;
  logic        i_rstn = 1'b0;
  logic [4:0]  i_addr = 5'h00;
  logic [15:0] i_wdata = 16'h0000;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [15:0] o_rdata;
  logic [7:0]  lnk = 8'h00;
  logic [4:0]  sts = 5'h00;
  logic [3:0]  loop_o;
  logic [3:0]  led_o;
  int          n_fail = 0;
  int          n_checks = 0;

  always #5 i_ref_clk = ~i_ref_clk;

  plsl_regs #(.BLINK_HALF_CYCLES(4)) plsl_regs_inst (
    .i_ref_clk                       (i_ref_clk),
    .i_rstn                          (i_rstn),
    .i_addr                          (i_addr),
    .i_wdata                         (i_wdata),
    .i_wr                            (i_wr),
    .i_rd                            (i_rd),
    .o_rdata                         (o_rdata),
    .i_link_up                       (lnk[7]),
    .i_link_speed                    (lnk[6:5]),
    .i_full_duplex                   (lnk[4]),
    .i_rx_active                     (lnk[3]),
    .i_tx_active                     (lnk[2]),
    .i_rx_error                      (lnk[1]),
    .i_tx_error                      (lnk[0]),
    .i_checker_locked                (sts[4]),
    .i_packet_generator_active       (sts[3]),
    .i_gigabit_scrambler_legacy_flag (sts[2]),
    .i_slave_scrambler_legacy_flag   (sts[1]),
    .i_core_power_state              (sts[0]),
    .o_loop_after_line_encoder       (loop_o[3]),
    .o_loop_after_scrambler          (loop_o[2]),
    .o_loop_before_scrambler         (loop_o[1]),
    .o_loop_before_gigabit_dsp       (loop_o[0]),
    .o_gp_led_output                 (led_o[3]),
    .o_led_two_output                (led_o[2]),
    .o_led_one_output                (led_o[1]),
    .o_led_zero_output               (led_o[0])
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask

  // Expected LED level for a source code from the current link inputs
  function automatic logic led_exp(input logic [3:0] c);
    logic up;
    up = lnk[7];
    case (c)
      4'h0: led_exp = up;
      4'h1: led_exp = lnk[3] | lnk[2];
      4'h2: led_exp = lnk[2];
      4'h4: led_exp = lnk[3];
      4'h5: led_exp = up && lnk[6:5] == 2'h2;
      4'h6: led_exp = up && lnk[6:5] == 2'h1;
      4'h7: led_exp = up && lnk[6:5] == 2'h0;
      4'h8: led_exp = up && (lnk[6:5] == 2'h0 || lnk[6:5] == 2'h1);
      4'h9: led_exp = up && (lnk[6:5] == 2'h1 || lnk[6:5] == 2'h2);
      4'hA: led_exp = up && lnk[4];
      4'hD: led_exp = lnk[1] | lnk[0];
      4'hE: led_exp = lnk[1];
      default: led_exp = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_and_map();
    logic [15:0] d;
    rd(5'h18, d);
    check(d, 16'h6150, "selector reset");
    rd(5'h16, d);
    check(d, 16'h0000, "loop reset");
    rd(5'h17, d);
    check(d, 16'h0000, "status reset");
    wr(5'h1F, 16'h0000);
    rd(5'h00, d);
    check(d, 16'h0000, "unmapped read");
    rd(5'h18, d);
    check(d, 16'h6150, "selector after stray write");
  endtask

  task automatic t_loop();
    logic [15:0] d;
    logic [1:0]  sp [3] = '{2'h1, 2'h2, 2'h0};
    logic [3:0]  exp_loop;
    for (int s = 0; s < 3; s++) begin
      for (int f = 0; f < 4; f++) begin
        @(posedge i_ref_clk);
        lnk <= {1'b1, sp[s], 5'h00};
        wr(5'h16, 16'(f));
        settle(3);
        exp_loop = {sp[s] == 2'h1 && f == 3, sp[s] == 2'h1 && f == 2,
                    sp[s] == 2'h1 && f == 1, sp[s] == 2'h2 && f[0]};
        check(16'(loop_o), 16'(exp_loop), "loop point");
      end
    end
    wr(5'h16, 16'hFFFE);
    rd(5'h16, d);
    check(d, 16'h0002, "loop field readback");
  endtask

  task automatic t_status();
    logic [15:0] d;
    @(posedge i_ref_clk);
    sts <= 5'b11011;
    settle(2);
    wr(5'h17, 16'hFFFF);
    rd(5'h17, d);
    check(d, 16'h0AC0, "status levels");
    @(posedge i_ref_clk);
    sts <= 5'b10100;
    settle(2);
    rd(5'h17, d);
    check(d, 16'h0900, "status master legacy");
    @(posedge i_ref_clk);
    sts <= 5'b00100;
    settle(3);
    rd(5'h17, d);
    check(d, 16'h0500, "lock lost latched");
    rd(5'h17, d);
    check(d, 16'h0100, "lock lost cleared by read");
  endtask

  task automatic t_led_codes();
    logic [7:0]  st [4] = '{8'hD2, 8'hA5, 8'h98, 8'h70};
    logic [15:0] want;
    for (int s = 0; s < 4; s++) begin
      @(posedge i_ref_clk);
      lnk <= st[s];
      for (int c = 0; c < 16; c++) begin
        if (c != 11) begin
          wr(5'h18, {4{4'(c)}});
          settle(3);
          want = 16'({4{led_exp(4'(c))}});
          check(16'(led_o), want, "led src");
        end
      end
    end
    @(posedge i_ref_clk);
    lnk <= 8'hD2;
    wr(5'h18, 16'hE702);
    settle(3);
    check(16'(led_o), 16'h000A, "selector field order");
  endtask

  task automatic t_blink();
    int ones;
    int zeros;
    ones  = 0;
    zeros = 0;
    @(posedge i_ref_clk);
    lnk <= 8'h80;
    wr(5'h18, 16'hBBBB);
    settle(3);
    for (int i = 0; i < 10; i++) begin
      settle(1);
      if (led_o === 4'hF) ones++;
    end
    check(16'(ones), 16'h000A, "blink code steady with link");
    @(posedge i_ref_clk);
    lnk <= 8'h88;
    ones = 0;
    for (int i = 0; i < 24; i++) begin
      settle(1);
      if (led_o === 4'hF) ones++;
      if (led_o === 4'h0) zeros++;
    end
    check(16'(ones > 0 && zeros > 0 && ones + zeros == 24), 16'h0001, "blink on activity");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    t_reset_and_map();
    t_loop();
    t_status();
    t_led_codes();
    t_blink();
    summarize();
  end

  initial begin
    repeat (20000) @(posedge i_ref_clk);
    n_fail++;
    $display("unexpected at %0t: run did not finish", $time);
    summarize();
  end

endmodule // tb
